//--- aehs_status.sv
// host handshake status and width control of the mailbox
// assumes host and controller strobes are one-cycle pulses on sys_clk,
// decoded by the data-byte registers outside this block
//
// Behaviour
// - management event flag bit 6, software only
// - query pending bit 5, firmware owned
// - burst flag bit 4, firmware owned
// - command write sets bit 3, data clears
// - command sets inbound-full, in0 read clears
// - single byte: byte 0 sets/clears inbound
// - four byte: byte 3 sets/clears inbound
// - single byte: out0 write sets outbound-full
// - four byte: out3 write sets outbound-full
// - host emptying outbound raises empty request
// - inbound-full raises request to controller
// - width bit 0, reset zero, rest reserved
// - host status mirrors controller status read-only
// - single byte: bytes 1-3 leave full flags alone
// - full flags survive host power-down
`timescale 1ns/1ps
`include "aehs_params.svh"
module aehs_status (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire aehs_pkg::aehs_acc_t host_acc,
  input wire aehs_pkg::aehs_acc_t ctl_acc,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] host_rdata,
  output logic [7:0] ctl_rdata,
  output logic cmd_flag,
  output logic four_byte_mode,
  output logic inbound_full_irq,
  output logic outbound_empty_irq
);
  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic four_byte;
  logic host_cmd_wr;
  logic host_data_wr;
  logic host_in_last_wr;
  logic host_out_last_rd;
  logic ctl_in_last_rd;
  logic ctl_out_last_wr;
  logic ctl_status_wr;
  logic ctl_width_wr;
  logic [3:0] in_last_ofs;
  logic [3:0] out_last_ofs;
  logic inbound_full;
  logic outbound_full;
  logic outbound_emptied;
  logic [7:0] sw_flags;
  logic [7:0] status_word;
  aehs_pkg::aehs_flag_ev_t ib_ev;
  aehs_pkg::aehs_flag_ev_t ob_ev;

  // width picks which byte closes a transfer, bytes 1-2 never count
  assign in_last_ofs = four_byte ? `AEHS_CTL_IN3_OFS : `AEHS_CTL_IN0_OFS;
  assign out_last_ofs = four_byte ? `AEHS_CTL_OUT3_OFS :
                        `AEHS_CTL_OUT0_OFS;
  assign host_cmd_wr = host_acc.wr &&
      (host_acc.ofs[2:0] == `AEHS_HOST_STATUS_OFS);
  assign host_data_wr = host_acc.wr && (host_acc.ofs[2:0] <=
      `AEHS_HOST_DATA3_OFS);
  // single byte mode: only byte 0 moves the full flags
  assign host_in_last_wr = host_data_wr && (host_acc.ofs[2:0] ==
      (four_byte ? `AEHS_HOST_DATA3_OFS : `AEHS_HOST_DATA0_OFS));
  assign host_out_last_rd = host_acc.rd && (host_acc.ofs[2:0] ==
      (four_byte ? `AEHS_HOST_DATA3_OFS : `AEHS_HOST_DATA0_OFS));
  // command-marked byte is always in0, width ignored
  assign ctl_in_last_rd = ctl_acc.rd && (cmd_flag ?
      (ctl_acc.ofs == `AEHS_CTL_IN0_OFS) : (ctl_acc.ofs == in_last_ofs));
  assign ctl_out_last_wr = ctl_acc.wr && (ctl_acc.ofs == out_last_ofs);
  assign ctl_status_wr = ctl_acc.wr &&
      (ctl_acc.ofs == `AEHS_CTL_STATUS_OFS);
  assign ctl_width_wr = ctl_acc.wr && (ctl_acc.ofs == `AEHS_CTL_WIDTH_OFS);

  // ---------------------------------------------------------------
  // full flags
  // ---------------------------------------------------------------
  // one driver per bundle; a per-member assign splits the variable
  assign ib_ev = '{
    set: host_cmd_wr || host_in_last_wr,
    clr: ctl_in_last_rd
  };
  assign ob_ev = '{
    set: ctl_out_last_wr,
    clr: host_out_last_rd
  };

  aehs_full_flag u_inbound (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ev(ib_ev),
    .full(inbound_full),
    .emptied()
  );

  aehs_full_flag u_outbound (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ev(ob_ev),
    .full(outbound_full),
    .emptied(outbound_emptied)
  );

  aehs_width_ctl u_width (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(ctl_width_wr),
    .wr_data(ctl_wdata),
    .four_byte(four_byte)
  );

  // ---------------------------------------------------------------
  // command marker and software flags
  // ---------------------------------------------------------------
  // command write sets, any host data byte write clears
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_flag <= 1'b0;
    end else if (host_cmd_wr) begin
      cmd_flag <= 1'b1;
    end else if (host_data_wr) begin
      cmd_flag <= 1'b0;
    end
  end

  // only firmware writes these; hardware never touches them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_flags <= `AEHS_STATUS_RESET;
    end else if (ctl_status_wr) begin
      sw_flags <= ctl_wdata & `AEHS_SW_MASK;
    end
  end

  // bits 6 and 5 are plain storage, no interrupt is derived
  always_comb begin
    status_word = sw_flags;
    status_word[`AEHS_BIT_CMD] = cmd_flag;
    status_word[`AEHS_BIT_INBOUND_FULL] = inbound_full;
    status_word[`AEHS_BIT_OUTBOUND_FULL] = outbound_full;
  end

  // ---------------------------------------------------------------
  // read data and requests, all registered
  // ---------------------------------------------------------------
  // host sees the same word firmware sees, without write access
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= 8'h00;
      ctl_rdata <= 8'h00;
    end else begin
      host_rdata <= 8'h00;
      ctl_rdata <= 8'h00;
      if (host_acc.ofs[2:0] == `AEHS_HOST_STATUS_OFS) begin
        host_rdata <= status_word;
      end else if (host_acc.ofs[2:0] == `AEHS_HOST_WIDTH_OFS) begin
        host_rdata <= {7'h00, four_byte};
      end
      if (ctl_acc.ofs == `AEHS_CTL_STATUS_OFS) begin
        ctl_rdata <= status_word;
      end else if (ctl_acc.ofs == `AEHS_CTL_WIDTH_OFS) begin
        ctl_rdata <= {7'h00, four_byte};
      end
    end
  end

  // level request while inbound holds data; pulse when outbound drained
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      inbound_full_irq <= 1'b0;
      outbound_empty_irq <= 1'b0;
      four_byte_mode <= 1'b0;
    end else begin
      inbound_full_irq <= inbound_full;
      outbound_empty_irq <= outbound_emptied;
      four_byte_mode <= four_byte;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_cmd_set;
    @(posedge sys_clk) disable iff (!arst_n)
    host_cmd_wr |=> cmd_flag && inbound_full;
  endproperty
  a_cmd_set: assert property (p_cmd_set)
    else $error("command write lost");

  property p_cmd_clr;
    @(posedge sys_clk) disable iff (!arst_n)
    host_data_wr && !host_cmd_wr |=> !cmd_flag;
  endproperty
  a_cmd_clr: assert property (p_cmd_clr)
    else $error("command marker not cleared");

  property p_cmd_in0_clr;
    @(posedge sys_clk) disable iff (!arst_n)
    cmd_flag && ctl_acc.rd && ctl_acc.ofs == `AEHS_CTL_IN0_OFS && !ib_ev.set
      |=> !inbound_full;
  endproperty
  a_cmd_in0_clr: assert property (p_cmd_in0_clr)
    else $error("inbound full stuck after command read");

  property p_ib_single;
    @(posedge sys_clk) disable iff (!arst_n)
    !four_byte && host_acc.wr && host_acc.ofs[2:0] == 3'h0 |=> inbound_full;
  endproperty
  a_ib_single: assert property (p_ib_single)
    else $error("inbound full not set by byte 0");

  property p_ib_four;
    @(posedge sys_clk) disable iff (!arst_n)
    four_byte && host_acc.wr && host_acc.ofs[2:0] == 3'h3 |=> inbound_full;
  endproperty
  a_ib_four: assert property (p_ib_four)
    else $error("inbound full not set by byte 3");

  property p_ob_single;
    @(posedge sys_clk) disable iff (!arst_n)
    !four_byte && ctl_acc.wr && ctl_acc.ofs == 4'h0 |=> outbound_full;
  endproperty
  a_ob_single: assert property (p_ob_single)
    else $error("outbound full not set by byte 0");

  property p_ob_four_clr;
    @(posedge sys_clk) disable iff (!arst_n)
    four_byte && host_acc.rd && host_acc.ofs[2:0] == 3'h3 && !ob_ev.set
      |=> !outbound_full;
  endproperty
  a_ob_four_clr: assert property (p_ob_four_clr)
    else $error("outbound full stuck after byte 3 read");

  property p_empty_irq;
    @(posedge sys_clk) disable iff (!arst_n)
    outbound_full && ob_ev.clr && !ob_ev.set |=> ##1 outbound_empty_irq;
  endproperty
  a_empty_irq: assert property (p_empty_irq)
    else $error("no outbound empty request");

  property p_ib_irq;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(inbound_full) |=> inbound_full_irq;
  endproperty
  a_ib_irq: assert property (p_ib_irq)
    else $error("no inbound full request");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!arst_n)
    ib_ev.set && ib_ev.clr |=> inbound_full;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("set lost to a clear");

  property p_sw_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !ctl_status_wr |=> $stable(sw_flags);
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("software flag moved without a write");

  // host bytes 1-3 in single byte mode must not move either flag
  property p_bytes_ignored;
    @(posedge sys_clk) disable iff (!arst_n)
    !four_byte && (host_acc.wr || host_acc.rd) && host_acc.ofs[2:0] != 3'h0
      && host_acc.ofs[2:0] <= 3'h3 && !ctl_acc.wr && !ctl_acc.rd
      |=> $stable(inbound_full) && $stable(outbound_full);
  endproperty
  a_bytes_ignored: assert property (p_bytes_ignored)
    else $error("unused byte moved a full flag");

  // no event, no change: power state of the host cannot clear a flag
  property p_flags_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !ib_ev.set && !ib_ev.clr && !ob_ev.set && !ob_ev.clr
      |=> $stable(inbound_full) && $stable(outbound_full);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("full flag moved without an event");

  property p_width_rsvd;
    @(posedge sys_clk) disable iff (!arst_n)
    ctl_acc.ofs == `AEHS_CTL_WIDTH_OFS |=> ctl_rdata[7:1] == 7'h00;
  endproperty
  a_width_rsvd: assert property (p_width_rsvd)
    else $error("reserved width bits not zero");

  property p_ib_irq_clr;
    @(posedge sys_clk) disable iff (!arst_n)
    $fell(inbound_full) |=> !inbound_full_irq;
  endproperty
  a_ib_irq_clr: assert property (p_ib_irq_clr)
    else $error("inbound request stuck after drain");

  // the host view carries the marker the controller sees
  property p_host_mirror;
    @(posedge sys_clk) disable iff (!arst_n)
    host_acc.rd && host_acc.ofs[2:0] == `AEHS_HOST_STATUS_OFS
      |=> host_rdata[`AEHS_BIT_CMD] == $past(cmd_flag);
  endproperty
  a_host_mirror: assert property (p_host_mirror)
    else $error("host status view differs");

  c_cmd: cover property (@(posedge sys_clk) disable iff (!arst_n)
    host_cmd_wr ##[1:20] ctl_in_last_rd);
  c_four: cover property (@(posedge sys_clk) disable iff (!arst_n)
    four_byte && ob_ev.set ##[1:20] ob_ev.clr);
  c_both: cover property (@(posedge sys_clk) disable iff (!arst_n)
    ib_ev.set && ib_ev.clr);
  c_irq: cover property (@(posedge sys_clk) disable iff (!arst_n)
    inbound_full_irq ##[1:20] !inbound_full_irq);
endmodule : aehs_status

//--- aehs_params.svh
// constants for the embedded-controller mailbox status and width block
// assumes byte-wide register offsets on both the host and controller side
`ifndef AEHS_PARAMS_SVH
`define AEHS_PARAMS_SVH
// host-side offsets
`define AEHS_HOST_DATA0_OFS 3'h0
`define AEHS_HOST_DATA3_OFS 3'h3
`define AEHS_HOST_STATUS_OFS 3'h4
`define AEHS_HOST_WIDTH_OFS 3'h5
// controller-side offsets
`define AEHS_CTL_OUT0_OFS 4'h0
`define AEHS_CTL_OUT3_OFS 4'h3
`define AEHS_CTL_STATUS_OFS 4'h4
`define AEHS_CTL_WIDTH_OFS 4'h5
`define AEHS_CTL_IN0_OFS 4'h8
`define AEHS_CTL_IN3_OFS 4'hB
// status bit positions
`define AEHS_BIT_SPARE_HIGH 7
`define AEHS_BIT_MGMT_EVT 6
`define AEHS_BIT_QUERY 5
`define AEHS_BIT_BURST 4
`define AEHS_BIT_CMD 3
`define AEHS_BIT_SPARE_LOW 2
`define AEHS_BIT_INBOUND_FULL 1
`define AEHS_BIT_OUTBOUND_FULL 0
`define AEHS_BIT_WIDTH 0
// reset values and firmware-writable mask
`define AEHS_STATUS_RESET 8'h00
`define AEHS_WIDTH_RESET 1'h0
`define AEHS_SW_MASK 8'hF4
`endif

//--- aehs_pkg.sv
// types for the embedded-controller mailbox status and width block
// assumes aehs_params.svh is compiled alongside
package aehs_pkg;
  // one access strobe with its offset
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] ofs;
  } aehs_acc_t;
  // full-flag event bundle
  typedef struct packed {
    logic set;
    logic clr;
  } aehs_flag_ev_t;
  // flag engine state
  typedef enum logic [1:0] {
    AEHS_EMPTY = 2'b01,
    AEHS_FULL = 2'b10
  } aehs_flag_st_t;
endpackage : aehs_pkg

//--- aehs_full_flag.sv
// one mailbox full flag, set wins over clear
// assumes set and clear are single-cycle pulses on sys_clk
`timescale 1ns/1ps
module aehs_full_flag (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire aehs_pkg::aehs_flag_ev_t ev,
  output logic full,
  output logic emptied
);
  aehs_pkg::aehs_flag_st_t state;
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // no path clears on host power-down, only bus events move it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= aehs_pkg::AEHS_EMPTY;
    end else begin
      case (state)
        aehs_pkg::AEHS_EMPTY: begin
          if (ev.set) begin
            state <= aehs_pkg::AEHS_FULL;
          end
        end
        aehs_pkg::AEHS_FULL: begin
          if (ev.clr && !ev.set) begin // set wins
            state <= aehs_pkg::AEHS_EMPTY;
          end
        end
        default: begin
          state <= aehs_pkg::AEHS_EMPTY;
        end
      endcase
    end
  end
  // emptied pulse for the outbound-empty request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      emptied <= 1'b0;
    end else begin
      emptied <= (state == aehs_pkg::AEHS_FULL) && ev.clr && !ev.set;
    end
  end
  assign full = (state == aehs_pkg::AEHS_FULL);
endmodule : aehs_full_flag

//--- aehs_width_ctl.sv
// transfer-width select, firmware-owned, host sees it read-only
// assumes the controller write strobe is one cycle per access
`timescale 1ns/1ps
`include "aehs_params.svh"
module aehs_width_ctl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic four_byte
);
  // only bit 0 is stored, the rest reads zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      four_byte <= `AEHS_WIDTH_RESET;
    end else if (wr_en) begin
      four_byte <= wr_data[`AEHS_BIT_WIDTH];
    end
  end
endmodule : aehs_width_ctl

//--- aehs_host_model.sv
// host side model: issues lpc i/o cycles into the mailbox status block
// assumes the bench hands it one single-cycle request at a time
`timescale 1ns/1ps
module aehs_host_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire aehs_pkg::aehs_acc_t req,
  output aehs_pkg::aehs_acc_t host_acc
);
  // ------------
  // cycle issue
  // ------------
  // one cycle of lpc latency; a cycle is never dropped halfway
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_acc <= '0;
    end else begin
      host_acc <= req; // caller keeps width and byte order
    end
  end
endmodule : aehs_host_model

//--- controller_firmware_host_handshake_status_bench.sv
// self-checking bench for the mailbox status and width block
// assumes aehs_pkg and aehs_host_model are compiled before it
`timescale 1ns/1ps
module controller_firmware_host_handshake_status_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  aehs_pkg::aehs_acc_t hreq = '0;
  aehs_pkg::aehs_acc_t host_acc;
  aehs_pkg::aehs_acc_t ctl_acc = '0;
  logic [7:0] ctl_wdata = 8'h00;
  logic [7:0] host_rdata;
  logic [7:0] ctl_rdata;
  logic cmd_flag;
  logic four_byte_mode;
  logic inbound_full_irq;
  logic outbound_empty_irq;
  logic look_c = 1'b0;
  logic look_h = 1'b0;
  logic cpipe = 1'b0;
  logic [1:0] hpipe = 2'h0;
  logic [7:0] expq [$];
  logic [7:0] v;
  int n_errors = 0;
  int comparisons = 0;
  int n_empty = 0;
  int seed = 32'hC6D5;

  always #50 sys_clk = ~sys_clk;

  aehs_host_model host_u (.sys_clk(sys_clk), .arst_n(arst_n), .req(hreq),
    .host_acc(host_acc));
  aehs_status dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .host_acc(host_acc), .ctl_acc(ctl_acc), .ctl_wdata(ctl_wdata),
    .host_rdata(host_rdata), .ctl_rdata(ctl_rdata), .cmd_flag(cmd_flag),
    .four_byte_mode(four_byte_mode), .inbound_full_irq(inbound_full_irq),
    .outbound_empty_irq(outbound_empty_irq));

  // ----------------
  // shared routines
  // ----------------
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    if (expq.size() != 0) n_errors++; // unanswered reads
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // host cycle; spacing leaves the flags settled for the next read
  task automatic host(input logic wr, input logic rd, input logic [3:0] ofs);
    hreq <= '{wr, rd, ofs};
    idle(1);
    hreq <= '0;
    idle(4);
  endtask : host

  task automatic ctl(input logic wr, input logic rd, input logic [3:0] ofs,
    input logic [7:0] d);
    ctl_acc <= '{wr, rd, ofs};
    ctl_wdata <= d;
    idle(1);
    ctl_acc <= '0;
    idle(3);
  endtask : ctl

  // controller read; the monitor compares one cycle later
  task automatic cread(input logic [3:0] ofs, input logic [7:0] exp);
    expq.push_back(exp);
    ctl_acc <= '{1'b0, 1'b1, ofs};
    look_c <= 1'b1;
    idle(1);
    ctl_acc <= '0;
    look_c <= 1'b0;
    idle(2);
  endtask : cread

  // host status read through the model, one extra cycle of latency
  task automatic hread(input logic [7:0] exp);
    expq.push_back(exp);
    hreq <= '{1'b0, 1'b1, 4'h4};
    look_h <= 1'b1;
    idle(1);
    hreq <= '0;
    look_h <= 1'b0;
    idle(3);
  endtask : hread

  // host set and controller clear land on the same edge
  task automatic clash;
    hreq <= '{1'b1, 1'b0, 4'h3};
    idle(1);
    hreq <= '0;
    ctl_acc <= '{1'b0, 1'b1, 4'hB};
    idle(1);
    ctl_acc <= '0;
    idle(3);
  endtask : clash

  task automatic pop(input string what, input logic [7:0] seen);
    if (expq.size() == 0) begin
      chk({what, " unexpected"}, seen, ~seen);
    end else begin
      chk(what, seen, expq.pop_front());
    end
  endtask : pop

  // --------
  // monitor
  // --------
  // empty pulse counted every cycle so a stretched pulse shows up
  always @(posedge sys_clk) begin
    if (cpipe) pop("ctl_rdata", ctl_rdata);
    if (hpipe[1]) pop("host_rdata", host_rdata);
    if (outbound_empty_irq === 1'b1) n_empty++;
    cpipe <= look_c;
    hpipe <= {hpipe[0], look_h};
  end

  // watchdog: a hang ends in the same report
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end

  // ---------------
  // main sequence
  // ---------------
  initial begin
    idle(16);
    arst_n <= 1'b1;
    idle(1);
    cread(4'h4, 8'h00);
    cread(4'h5, 8'h00);
    repeat (4) begin
      v = 8'($random(seed));
      ctl(1'b1, 1'b0, 4'h4, v);
      cread(4'h4, v & 8'hF4);
      hread(v & 8'hF4);
    end
    ctl(1'b1, 1'b0, 4'h4, 8'h00);
    host(1'b1, 1'b0, 4'h4);
    cread(4'h4, 8'h0A);
    chk("cmd_flag", {7'h0, cmd_flag}, 8'h01);
    chk("inbound_full_irq", {7'h0, inbound_full_irq}, 8'h01);
    ctl(1'b0, 1'b1, 4'h8, 8'h00); // firmware drains inbound
    cread(4'h4, 8'h08);
    chk("inbound_full_irq", {7'h0, inbound_full_irq}, 8'h00);
    host(1'b1, 1'b0, 4'h1);
    cread(4'h4, 8'h00);
    host(1'b1, 1'b0, 4'h0);
    cread(4'h4, 8'h02);
    ctl(1'b0, 1'b1, 4'h9, 8'h00);
    cread(4'h4, 8'h02);
    ctl(1'b0, 1'b1, 4'h8, 8'h00);
    cread(4'h4, 8'h00);
    ctl(1'b1, 1'b0, 4'h0, 8'($random(seed)));
    cread(4'h4, 8'h01);
    host(1'b0, 1'b1, 4'h3);
    cread(4'h4, 8'h01);
    host(1'b0, 1'b1, 4'h0);
    cread(4'h4, 8'h00);
    chk("empty pulses", 8'(n_empty), 8'h01);
    ctl(1'b1, 1'b0, 4'h5, 8'hFF);
    cread(4'h5, 8'h01);
    chk("four_byte_mode", {7'h0, four_byte_mode}, 8'h01);
    host(1'b1, 1'b0, 4'h5);
    cread(4'h5, 8'h01);
    host(1'b1, 1'b0, 4'h4);
    ctl(1'b0, 1'b1, 4'h8, 8'h00);
    cread(4'h4, 8'h08);
    host(1'b1, 1'b0, 4'h0);
    cread(4'h4, 8'h00);
    host(1'b1, 1'b0, 4'h3);
    cread(4'h4, 8'h02);
    ctl(1'b0, 1'b1, 4'h8, 8'h00);
    cread(4'h4, 8'h02);
    clash();
    cread(4'h4, 8'h02);
    ctl(1'b0, 1'b1, 4'hB, 8'h00);
    cread(4'h4, 8'h00);
    ctl(1'b1, 1'b0, 4'h0, 8'($random(seed)));
    cread(4'h4, 8'h00);
    ctl(1'b1, 1'b0, 4'h3, 8'($random(seed)));
    hread(8'h01); // host polls before draining
    host(1'b0, 1'b1, 4'h0);
    cread(4'h4, 8'h01);
    host(1'b0, 1'b1, 4'h3);
    cread(4'h4, 8'h00);
    chk("empty pulses", 8'(n_empty), 8'h02);
    stop_test();
  end
endmodule : controller_firmware_host_handshake_status_bench
